// File: hw/ate_delay_line.sv
// Programmable trigger delay, counted in sample clocks.
// Assumes start is a one-cycle pulse on the same clock; one event at a time.
`timescale 1ns/1ps
`default_nettype none
module ate_delay_line (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Engine side
   ate_dly_if.line dly
);

   logic [ate_pkg::DELAY_W-1:0] count_q;
   logic busy_q;
   logic fire_q;
   logic expired;

   // Zero length fires on the edge after start: only the fixed latency remains
   assign expired = (count_q == '0);

   // A start while busy is dropped; the engine never issues one
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         count_q <= '0;
         busy_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         if (dly.start && !busy_q) begin
            count_q <= dly.length;
            busy_q <= 1'b1;
         end else if (busy_q && expired) begin
            busy_q <= 1'b0;
            fire_q <= 1'b1;
         end else if (busy_q) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   assign dly.fire = fire_q;
   assign dly.busy = busy_q;

endmodule
`default_nettype wire

// File: hw/ate_dly_if.sv
// Link between the trigger engine and its delay stage.
// Both ends run on the sample clock.
`timescale 1ns/1ps
`default_nettype none
interface ate_dly_if;
   logic start;
   logic [ate_pkg::DELAY_W-1:0] length;
   logic fire;
   logic busy;
   modport engine (output start, output length, input fire, input busy);
   modport line (input start, input length, output fire, output busy);
endinterface
`default_nettype wire

// File: hw/ate_pkg.sv
// Constants, register map and types of the acquisition trigger engine.
// Assumes a 32-bit APB slave whose register index sits in paddr[17:2].
package ate_pkg;

   // Register indices; the byte address is four times the index
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_CARD_COMMAND = 16'h0064;
   localparam logic [15:0] IDX_TRIGGER_OUTPUT_CONTROL = 16'h9ca4;
   localparam logic [15:0] IDX_GENERAL_OR_SELECT = 16'h9dda;
   localparam logic [15:0] IDX_GENERAL_AND_AVAILABLE = 16'h9de4;
   localparam logic [15:0] IDX_GENERAL_AND_SELECT = 16'h9dee;
   localparam logic [15:0] IDX_CHANNEL_AND_AVAILABLE_LOW = 16'h9e16;
   localparam logic [15:0] IDX_CHANNEL_AND_AVAILABLE_HIGH = 16'h9e17;
   localparam logic [15:0] IDX_CHANNEL_AND_SELECT_LOW = 16'h9e20;
   localparam logic [15:0] IDX_CHANNEL_AND_SELECT_HIGH = 16'h9e21;
   localparam logic [15:0] IDX_DELAY_MAXIMUM = 16'h9f60;
   localparam logic [15:0] IDX_DELAY_LENGTH = 16'h9f6a;
   localparam logic [15:0] IDX_ENGINE_STATUS = 16'h9f70;

   // Bit positions in the general masks
   localparam int FREE_RUN_BIT = 0;
   localparam int EXT_INPUT_ZERO_BIT = 1;
   localparam int EXT_INPUT_ONE_BIT = 2;
   localparam int EXTRA_IO_ZERO_BIT = 8;
   localparam int EXTRA_IO_ONE_BIT = 9;

   // Command bits in card_command
   localparam int ARM_ENGINE_CMD_BIT = 3;
   localparam int FORCE_EVENT_CMD_BIT = 4;
   localparam int DISARM_ENGINE_CMD_BIT = 5;

   // What this build provides: both external inputs, both extra inputs, four channels
   localparam logic [31:0] GENERAL_AND_AVAIL = 32'h0000_0306;
   localparam logic [31:0] GENERAL_OR_AVAIL = 32'h0000_0307;
   localparam logic [31:0] CHANNEL_AND_AVAIL_LOW = 32'h0000_000f;
   localparam logic [31:0] CHANNEL_AND_AVAIL_HIGH = 32'h0000_0000;

   // Delay stage
   localparam int DELAY_W = 16;
   localparam logic [31:0] DELAY_MAXIMUM = 32'h0000_ffff;

   // Reset values
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0000;
   localparam logic TRIG_OUTPUT_RESET = 1'b0;

   // Engine states
   typedef enum logic [1:0] {
      ST_DISARMED,
      ST_WAITING,
      ST_DELAYING,
      ST_RUNNING
   } ate_state_e;

endpackage

// File: hw/ate_trigger_engine.sv
// Acquisition trigger engine: AND and OR masks, commands, trigger output, delay.
// Assumes an APB master on ref_clk and channel triggers from same-clock logic.
//
// How it works
// - General AND mask bit 2h selects external input zero, 4h input one.
// - General AND mask bits 100h and 200h select the two extra inputs.
// - Software trigger has no AND mask bit; all other sources do.
// - Channel AND mask: low register channels 0-31, high register 32-63.
// - Read-only availability registers show which mask bits exist.
// - OR mask bit 1h selects the free-running software trigger.
// - Output control 0 leaves connector undriven; 1 drives trigger events out.
// - Driven trigger output is active high from acquisition start.
// - When external input zero is selected, the connector is an input.
// - Command 10h forces an event only while waiting for a trigger.
// - Command 8h arms the engine.
// - Command 20h disarms the engine; nothing is recognised.
// - After reset the engine is armed.
// - The delay is the last stage, common to all sources.
// - Delay 0 to 65535 sample clocks beyond fixed latency; zero adds none.
// - A read-only register reports the largest delay.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ate_trigger_engine (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,

   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ate_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,

   // Trigger connector, also external input zero
   input wire logic trigIoIn,
   output logic trigIoOut,
   output logic trigIoOe,

   // Further external pins
   input wire logic extTrigOne,
   input wire logic extraIoZero,
   input wire logic extraIoOne,

   // Channel triggers from the channel logic, same clock
   input wire logic [63:0] chanTrig,

   // Acquisition side
   input wire logic acqDone,
   output logic trigEvent,
   output logic engineArmed
);

   // Register index from a byte address
   function automatic logic [15:0] regIndex(input logic [ate_pkg::ADDR_W-1:0] a);
      regIndex = a[ate_pkg::ADDR_W-1:2];
   endfunction

   // All selected sources true, and at least one selected
   function automatic logic allSelectedTrue(input logic [95:0] sel, input logic [95:0] src);
      allSelectedTrue = (|sel) && ((sel & ~src) == '0);
   endfunction

   ate_dly_if dly ();

   ate_delay_line u_delay (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .dly(dly)
   );

   // Configuration
   logic [31:0] genAndSel_q;
   logic [31:0] genOrSel_q;
   logic [31:0] chAndSelLow_q;
   logic [31:0] chAndSelHigh_q;
   logic [ate_pkg::DELAY_W-1:0] delayLen_q;
   logic trigOutCtrl_q;

   // Bus answer
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // Engine
   ate_pkg::ate_state_e state_q;
   ate_pkg::ate_state_e state_d;

   // Outputs
   logic trigIoOut_q;
   logic trigIoOe_q;
   logic trigEvent_q;
   logic engineArmed_q;

   // Pin synchronisers
   logic [3:0] pinMeta_q;
   logic [3:0] pinSync_q;

   // Bus decode
   logic access;
   logic wrAccess;
   logic rdAccess;
   logic [15:0] idx;
   logic hitCommand;
   logic hitOutCtrl;
   logic hitOrSel;
   logic hitGenAvail;
   logic hitGenAndSel;
   logic hitChAvailLow;
   logic hitChAvailHigh;
   logic hitChAndLow;
   logic hitChAndHigh;
   logic hitDelayMax;
   logic hitDelayLen;
   logic hitStatus;
   logic mapped;
   logic [31:0] readMux;

   // paddr[1:0] is ignored; each register is one aligned word
   // The answer comes one cycle into the access phase, so all APB outputs are flops
   assign access = psel && penable && !pready_q;
   assign wrAccess = access && pwrite;
   assign rdAccess = access && !pwrite;
   assign idx = regIndex(paddr);
   assign hitCommand = (idx == ate_pkg::IDX_CARD_COMMAND);
   assign hitOutCtrl = (idx == ate_pkg::IDX_TRIGGER_OUTPUT_CONTROL);
   assign hitOrSel = (idx == ate_pkg::IDX_GENERAL_OR_SELECT);
   assign hitGenAvail = (idx == ate_pkg::IDX_GENERAL_AND_AVAILABLE);
   assign hitGenAndSel = (idx == ate_pkg::IDX_GENERAL_AND_SELECT);
   assign hitChAvailLow = (idx == ate_pkg::IDX_CHANNEL_AND_AVAILABLE_LOW);
   assign hitChAvailHigh = (idx == ate_pkg::IDX_CHANNEL_AND_AVAILABLE_HIGH);
   assign hitChAndLow = (idx == ate_pkg::IDX_CHANNEL_AND_SELECT_LOW);
   assign hitChAndHigh = (idx == ate_pkg::IDX_CHANNEL_AND_SELECT_HIGH);
   assign hitDelayMax = (idx == ate_pkg::IDX_DELAY_MAXIMUM);
   assign hitDelayLen = (idx == ate_pkg::IDX_DELAY_LENGTH);
   assign hitStatus = (idx == ate_pkg::IDX_ENGINE_STATUS);
   assign mapped = hitCommand || hitOutCtrl || hitOrSel || hitGenAvail || hitGenAndSel
                   || hitChAvailLow || hitChAvailHigh || hitChAndLow || hitChAndHigh
                   || hitDelayMax || hitDelayLen || hitStatus;

   // Read data; write-only command reads as zero
   assign readMux = hitOutCtrl ? {31'd0, trigOutCtrl_q} :
                    hitOrSel ? genOrSel_q :
                    hitGenAvail ? ate_pkg::GENERAL_AND_AVAIL :
                    hitGenAndSel ? genAndSel_q :
                    hitChAvailLow ? ate_pkg::CHANNEL_AND_AVAIL_LOW :
                    hitChAvailHigh ? ate_pkg::CHANNEL_AND_AVAIL_HIGH :
                    hitChAndLow ? chAndSelLow_q :
                    hitChAndHigh ? chAndSelHigh_q :
                    hitDelayMax ? ate_pkg::DELAY_MAXIMUM :
                    hitDelayLen ? {16'd0, delayLen_q} :
                    hitStatus ? {30'd0, state_q} :
                    32'h0000_0000;

   // Command decode; disarm beats arm and force when bits are combined
   logic cmdWrite;
   logic cmdArm;
   logic cmdForce;
   logic cmdDisarm;
   assign cmdWrite = wrAccess && hitCommand;
   assign cmdDisarm = cmdWrite && pwdata[ate_pkg::DISARM_ENGINE_CMD_BIT];
   assign cmdArm = cmdWrite && pwdata[ate_pkg::ARM_ENGINE_CMD_BIT];
   assign cmdForce = cmdWrite && pwdata[ate_pkg::FORCE_EVENT_CMD_BIT];

   // Synchronised external pins: {extra one, extra zero, ext one, connector}
   logic extZero;
   logic extOne;
   logic xioZero;
   logic xioOne;
   assign extZero = pinSync_q[0];
   assign extOne = pinSync_q[1];
   assign xioZero = pinSync_q[2];
   assign xioOne = pinSync_q[3];

   // General source vector in mask bit order; bit 0 stays clear for AND use
   logic [31:0] genSrc;
   always_comb begin
      genSrc = 32'h0000_0000;
      genSrc[ate_pkg::EXT_INPUT_ZERO_BIT] = extZero;
      genSrc[ate_pkg::EXT_INPUT_ONE_BIT] = extOne;
      genSrc[ate_pkg::EXTRA_IO_ZERO_BIT] = xioZero;
      genSrc[ate_pkg::EXTRA_IO_ONE_BIT] = xioOne;
   end

   // AND stage over general and channel sources, one combined condition
   logic andHit;
   assign andHit = allSelectedTrue({chAndSelHigh_q, chAndSelLow_q, genAndSel_q},
                                   {chanTrig, genSrc});

   // OR stage: free-run bit fires at once, external bits on their level
   logic freeRun;
   logic orHit;
   assign freeRun = genOrSel_q[ate_pkg::FREE_RUN_BIT];
   assign orHit = freeRun || (|(genOrSel_q & genSrc));

   // Selecting external input zero in either mask claims the connector as an input
   logic extInUse;
   assign extInUse = genAndSel_q[ate_pkg::EXT_INPUT_ZERO_BIT]
                     || genOrSel_q[ate_pkg::EXT_INPUT_ZERO_BIT];

   // Detection counts only while waiting; disarmed state ignores every source
   // A cancelled countdown may still run: wait until the line is free
   logic detect;
   assign detect = (state_q == ate_pkg::ST_WAITING) && !dly.busy
                   && (andHit || orHit || cmdForce) && !cmdDisarm;

   // All sources meet here, ahead of the single delay stage
   assign dly.start = detect;
   assign dly.length = delayLen_q;

   // Engine sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         ate_pkg::ST_DISARMED: begin
            if (cmdArm && !cmdDisarm) begin
               state_d = ate_pkg::ST_WAITING;
            end
         end
         ate_pkg::ST_WAITING: begin
            if (cmdDisarm) begin
               state_d = ate_pkg::ST_DISARMED;
            end else if (detect) begin
               state_d = ate_pkg::ST_DELAYING;
            end
         end
         ate_pkg::ST_DELAYING: begin
            if (cmdDisarm) begin
               state_d = ate_pkg::ST_DISARMED;
            end else if (dly.fire) begin
               state_d = ate_pkg::ST_RUNNING;
            end
         end
         ate_pkg::ST_RUNNING: begin
            if (cmdDisarm) begin
               state_d = ate_pkg::ST_DISARMED;
            end else if (acqDone) begin
               state_d = ate_pkg::ST_WAITING;
            end
         end
         default: begin
            state_d = ate_pkg::ST_WAITING;
         end
      endcase
   end

   // Two-flop pin synchronisers; only the second stage is read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
      end else begin
         pinMeta_q <= {extraIoOne, extraIoZero, extTrigOne, trigIoIn};
         pinSync_q <= pinMeta_q;
      end
   end

   // APB handshake and read data
   // A lone penable without psel is ignored
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access;
         pslverr_q <= access && !mapped;
         prdata_q <= rdAccess ? readMux : 32'h0000_0000;
      end
   end

   // Mask and control writes; bits the hardware lacks are not stored
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         genAndSel_q <= ate_pkg::MASK_RESET;
         genOrSel_q <= ate_pkg::MASK_RESET;
         chAndSelLow_q <= ate_pkg::MASK_RESET;
         chAndSelHigh_q <= ate_pkg::MASK_RESET;
         delayLen_q <= ate_pkg::DELAY_RESET;
         trigOutCtrl_q <= ate_pkg::TRIG_OUTPUT_RESET;
      end else if (wrAccess) begin
         if (hitGenAndSel) begin
            genAndSel_q <= pwdata & ate_pkg::GENERAL_AND_AVAIL;
         end
         if (hitOrSel) begin
            genOrSel_q <= pwdata & ate_pkg::GENERAL_OR_AVAIL;
         end
         if (hitChAndLow) begin
            chAndSelLow_q <= pwdata & ate_pkg::CHANNEL_AND_AVAIL_LOW;
         end
         if (hitChAndHigh) begin
            chAndSelHigh_q <= pwdata & ate_pkg::CHANNEL_AND_AVAIL_HIGH;
         end
         if (hitDelayLen) begin
            delayLen_q <= pwdata[ate_pkg::DELAY_W-1:0];
         end
         if (hitOutCtrl) begin
            trigOutCtrl_q <= pwdata[0];
         end
      end
   end

   // Engine state; reset lands in the armed, waiting state
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ate_pkg::ST_WAITING;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs from flops; connector high while acquisition runs after a trigger
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         trigIoOe_q <= 1'b0;
         trigIoOut_q <= 1'b0;
         trigEvent_q <= 1'b0;
         engineArmed_q <= 1'b1;
      end else begin
         trigIoOe_q <= trigOutCtrl_q && !extInUse;
         trigIoOut_q <= (state_d == ate_pkg::ST_RUNNING);
         trigEvent_q <= dly.fire && (state_q == ate_pkg::ST_DELAYING) && !cmdDisarm;
         engineArmed_q <= (state_d != ate_pkg::ST_DISARMED);
      end
   end

   // Ports straight from their flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign trigIoOut = trigIoOut_q;
   assign trigIoOe = trigIoOe_q;
   assign trigEvent = trigEvent_q;
   assign engineArmed = engineArmed_q;

endmodule
`default_nettype wire

// File: verification/ate_acq_model.sv
// Far side model: trigger connector wire and the acquisition that ends each run.
// Assumes one sample clock; acquisition lasts ACQ_LEN cycles after each event.
`timescale 1ns/1ps
`default_nettype none
module ate_acq_model #(
   parameter int ACQ_LEN = 30
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Engine side
   input wire logic trigEvent,
   input wire logic trigIoOut,
   input wire logic trigIoOe,
   // Outside equipment level on the connector
   input wire logic extLevel,
   output logic trigIoIn,
   output logic acqDone
);
   int cnt_q;

   // Connector resolves to whoever drives it; the engine wins when enabled
   assign trigIoIn = trigIoOe ? trigIoOut : extLevel;

   // Acquisition run: a stale run still ends, like the real recorder
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 0;
         acqDone <= 1'b0;
      end else begin
         acqDone <= (cnt_q == 1);
         if (trigEvent) begin
            cnt_q <= ACQ_LEN;
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/ate_tb.sv
// Self-checking bench of the trigger engine over APB with an acquisition model.
// Assumes the engine answers each access by pready and the model ends runs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // Short names for the register indices used often
   localparam logic [15:0] CMD = ate_pkg::IDX_CARD_COMMAND;
   localparam logic [15:0] ORS = ate_pkg::IDX_GENERAL_OR_SELECT;
   localparam logic [15:0] ANDS = ate_pkg::IDX_GENERAL_AND_SELECT;
   localparam logic [15:0] CHL = ate_pkg::IDX_CHANNEL_AND_SELECT_LOW;
   localparam logic [15:0] DLY = ate_pkg::IDX_DELAY_LENGTH;
   localparam logic [15:0] OUTC = ate_pkg::IDX_TRIGGER_OUTPUT_CONTROL;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, errv;
   logic extLevel, extTrigOne, extraIoZero, extraIoOne, trigIoIn, trigIoOut, trigIoOe;
   logic acqDone, trigEvent, engineArmed;
   logic [ate_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [63:0] chanTrig;
   int miscompares = 0, n_compared = 0, cyc = 0, n0, n1;

   ate_trigger_engine i_ate_trigger_engine (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigIoIn(trigIoIn), .trigIoOut(trigIoOut),
      .trigIoOe(trigIoOe), .extTrigOne(extTrigOne), .extraIoZero(extraIoZero),
      .extraIoOne(extraIoOne), .chanTrig(chanTrig), .acqDone(acqDone),
      .trigEvent(trigEvent), .engineArmed(engineArmed));
   ate_acq_model i_ate_acq_model (.ref_clk(ref_clk), .resetn(resetn), .trigEvent(trigEvent),
      .trigIoOut(trigIoOut), .trigIoOe(trigIoOe), .extLevel(extLevel), .trigIoIn(trigIoIn),
      .acqDone(acqDone));

   // Sample clock, 8 ns
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic give_verdict;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, w, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp, input string w);
      chk({31'h0, got}, {31'h0, exp}, w);
   endtask

   // One APB transfer; an idle edge first so a release never meets a new setup
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string w);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rdv, exp, w);
   endtask

   task automatic cnt_ev(output int n);
      n = 0;
      while (trigEvent !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic no_ev(input int n, input string w);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge ref_clk);
         if (trigEvent !== 1'b0) seen = 1'b1;
      end
      chkb(seen, 1'b0, w);
   endtask

   task automatic ev_in(input int m, input string w);
      int n;
      cnt_ev(n);
      chkb(n < m, 1'b1, w);
   endtask

   // Wait for the acquisition run to end
   task automatic settle;
      int n;
      n = 0;
      while (trigIoOut !== 1'b0 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chkb(trigIoOut, 1'b0, "run end");
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t_regs;
      rdchk(ate_pkg::IDX_GENERAL_AND_AVAILABLE, ate_pkg::GENERAL_AND_AVAIL, "and avail");
      rdchk(ate_pkg::IDX_CHANNEL_AND_AVAILABLE_LOW, ate_pkg::CHANNEL_AND_AVAIL_LOW, "ch lo");
      rdchk(ate_pkg::IDX_CHANNEL_AND_AVAILABLE_HIGH, 32'h0000_0000, "ch hi avail");
      wr(ate_pkg::IDX_DELAY_MAXIMUM, 32'h0000_0000);
      rdchk(ate_pkg::IDX_DELAY_MAXIMUM, 32'h0000_ffff, "delay max");
      rdchk(ANDS, 32'h0000_0000, "and reset");
      rdchk(CMD, 32'h0000_0000, "command reads zero");
      apb(1'b0, 16'h0001, 32'h0000_0000);
      chkb(errv, 1'b1, "unmapped error");
      chkb(engineArmed, 1'b1, "armed at reset");
   endtask

   task automatic t_masks;
      wr(ANDS, 32'h0000_0307);
      rdchk(ANDS, 32'h0000_0306, "and select");
      wr(CHL, 32'hffff_ffff);
      rdchk(CHL, ate_pkg::CHANNEL_AND_AVAIL_LOW, "ch lo select");
      wr(ate_pkg::IDX_CHANNEL_AND_SELECT_HIGH, 32'hffff_ffff);
      rdchk(ate_pkg::IDX_CHANNEL_AND_SELECT_HIGH, 32'h0000_0000, "ch hi select");
      wr(CHL, 32'h0000_0000);
   endtask

   task automatic t_and;
      wr(ANDS, 32'h0000_0306);
      {extLevel, extTrigOne, extraIoZero} <= 3'h7;
      no_ev(20, "partial and");
      extraIoOne <= 1'b1;
      ev_in(20, "full and");
      {extLevel, extTrigOne, extraIoZero, extraIoOne} <= 4'h0;
      settle;
      wr(ANDS, 32'h0000_0000);
      wr(CHL, 32'h0000_0005);
      chanTrig <= 64'h0000_0000_0000_0001;
      no_ev(20, "partial channels");
      chanTrig <= 64'h0000_0000_0000_0005;
      ev_in(20, "channel and");
      chanTrig <= 64'h0000_0000_0000_0000;
      settle;
      wr(CHL, 32'h0000_0000);
      {extLevel, extTrigOne, extraIoZero, extraIoOne} <= 4'hf;
      chanTrig <= 64'h0000_0000_0000_0005;
      no_ev(20, "empty masks");
      {extLevel, extTrigOne, extraIoZero, extraIoOne} <= 4'h0;
      chanTrig <= 64'h0000_0000_0000_0000;
   endtask

   task automatic t_output;
      wr(OUTC, 32'h0000_0001);
      rdchk(OUTC, 32'h0000_0001, "output ctrl");
      chkb(trigIoOe, 1'b1, "driver on");
      wr(CMD, 32'h0000_0010);
      cnt_ev(n0);
      chkb(trigIoOut, 1'b1, "output at event");
      settle;
      wr(ORS, 32'h0000_0002);
      repeat (3) @(posedge ref_clk);
      chkb(trigIoOe, 1'b0, "external mode");
      wr(ORS, 32'h0000_0000);
      wr(OUTC, 32'h0000_0000);
      repeat (3) @(posedge ref_clk);
      chkb(trigIoOe, 1'b0, "driver off");
   endtask

   task automatic t_cmd;
      wr(CMD, 32'h0000_0020);
      repeat (2) @(posedge ref_clk);
      chkb(engineArmed, 1'b0, "disarmed");
      wr(ORS, 32'h0000_0001);
      wr(CMD, 32'h0000_0010);
      no_ev(20, "disarmed quiet");
      wr(CMD, 32'h0000_0008);
      ev_in(20, "armed free run");
      wr(CMD, 32'h0000_0020);
      settle;
      wr(ORS, 32'h0000_0000);
      wr(CMD, 32'h0000_0008);
      wr(CMD, 32'h0000_0010);
      ev_in(20, "force");
      wr(CMD, 32'h0000_0010);
      no_ev(50, "force while busy");
   endtask

   // Latency of one trigger from a given source with a given delay
   task automatic lat(input logic [15:0] d, input logic frc, output int n);
      wr(CMD, 32'h0000_0020);
      wr(DLY, {16'h0000, d});
      wr(ORS, {31'h0, !frc});
      wr(CMD, 32'h0000_0008);
      if (frc) wr(CMD, 32'h0000_0010);
      cnt_ev(n);
      wr(CMD, 32'h0000_0020);
      settle;
      wr(ORS, 32'h0000_0000);
      wr(CMD, 32'h0000_0008);
   endtask

   task automatic t_delay;
      lat(16'h0000, 1'b0, n0);
      lat(16'h0009, 1'b0, n1);
      chk(32'(n1 - n0), 32'h0000_0009, "free run delay");
      lat(16'h0000, 1'b1, n0);
      lat(16'h0009, 1'b1, n1);
      chk(32'(n1 - n0), 32'h0000_0009, "force delay");
      wr(DLY, 32'h0000_ffff);
      rdchk(DLY, 32'h0000_ffff, "delay top");
      wr(DLY, 32'h0000_0000);
   endtask

   // Main sequence
   initial begin
      {resetn, psel, penable, pwrite, extLevel, extTrigOne, extraIoZero, extraIoOne} = 8'h00;
      paddr = '0;
      pwdata = 32'h0000_0000;
      chanTrig = 64'h0000_0000_0000_0000;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs;
      t_masks;
      t_and;
      t_output;
      t_cmd;
      t_delay;
      give_verdict;
   end
endmodule
`default_nettype wire

// File: verification/ate_trigger_engine_props.sv
// Checker for the trigger engine: APB handshake, commands, connector, event pulse.
// Assumes it sees only the top module's ports, all on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ate_trigger_engine_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ate_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Trigger side
   input wire logic trigIoOut,
   input wire logic trigIoOe,
   input wire logic trigEvent,
   input wire logic engineArmed
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Decode of writes as the design takes them
   wire logic [15:0] regIdx = paddr[17:2];
   wire logic wrTaken = psel && penable && pwrite && !pready;
   wire logic cmdWr = wrTaken && (regIdx == ate_pkg::IDX_CARD_COMMAND);
   wire logic selWr = (regIdx == ate_pkg::IDX_GENERAL_AND_SELECT)
      || (regIdx == ate_pkg::IDX_GENERAL_OR_SELECT);
   wire logic extSel = wrTaken && selWr && pwdata[ate_pkg::EXT_INPUT_ZERO_BIT];
   wire logic outOff = wrTaken && (regIdx == ate_pkg::IDX_TRIGGER_OUTPUT_CONTROL) && !pwdata[0];

   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or longer than a cycle");
   a_error_timing: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_reset_armed: assert property ($rose(resetn) |-> engineArmed)
      else $error("engine not armed after reset");
   a_disarm_cmd: assert property (cmdWr && pwdata[5] |-> ##2 !engineArmed)
      else $error("disarm command ignored");
   a_arm_cmd: assert property (cmdWr && pwdata[3] && !pwdata[5] |-> ##2 engineArmed)
      else $error("arm command ignored");
   a_no_disarmed: assert property (trigEvent |-> engineArmed)
      else $error("trigger while disarmed");
   a_event_pulse: assert property (trigEvent |=> !trigEvent)
      else $error("trigger event longer than a cycle");
   a_event_output: assert property (trigEvent |-> trigIoOut)
      else $error("trigger output low at event");
   a_ext_input: assert property (extSel |-> ##2 !trigIoOe)
      else $error("connector driven in external mode");
   a_output_off: assert property (outOff |-> ##2 !trigIoOe)
      else $error("connector driven with output off");
endmodule

bind ate_trigger_engine ate_trigger_engine_props i_ate_trigger_engine_props (
   .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .trigIoOut(trigIoOut), .trigIoOe(trigIoOe), .trigEvent(trigEvent),
   .engineArmed(engineArmed)
);
`default_nettype wire
